/* rtl/bus_cycle_sequencer.v */
// External bus cycle sequencer: five-phase cycles, READY, arbitration.
// Assumes CLK_SYS_IN is the CPU clock; requests come from the same clock.
//
// Function
// (R1) Five phases: setup, delay, wsetup, access, hold
// (R2) Phase lengths from per-window timing registers
// (R3) Setup 1-2 periods, plus 0-3 on window change
// (R4) Command delay 0-3, write setup 0-1
// (R5) Access 1-32 periods, READY may stretch it
// (R6) Hold phase 0-3 periods
// (R7) All phases counted in CPU clock periods
// (R8) READY active level selectable
// (R9) Sync READY: no extra stage
// (R10) Async READY: extra stage, one wait
// (R11) Partner holds async READY one clock
// (R12) READY inactive inserts wait; active ends cycle
// (R13) READY evaluated only after mandatory access periods
// (R14) Partner may drop READY after strobe rises
// (R15) Partner drops READY before next cycle samples
// (R16) Read data caught on strobe-raising edge
// (R17) Finish running cycle before releasing bus
// (R18) Drive controls inactive, ALE low, then float
// (R19) Regain starts only when release request ends
// (R20) Release request may end without regain request
// (R21) On regain drive controls inactive before cycle
// (R22) Float with ack; regain drops ack, request
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "bus_cycle_defines.vh"

module bus_cycle_sequencer #(
    parameter AW = 24,
    parameter DW = 16
) (
    input  wire          CLK_SYS_IN,
    input  wire          RST_B_IN,
    input  wire          CE_IN,
    // Register port
    input  wire [7:0]    REG_ADDR_IN,
    input  wire [31:0]   REG_WDATA_IN,
    input  wire          REG_WR_IN,
    input  wire          REG_RD_IN,
    output reg  [31:0]   REG_RDATA_OUT,
    // CPU bus request port
    input  wire          REQ_IN,
    input  wire          REQ_WR_IN,
    input  wire          REQ_WIN_IN,
    input  wire [AW-1:0] REQ_ADDR_IN,
    input  wire [DW-1:0] REQ_WDATA_IN,
    output reg           BUSY_OUT,
    output reg           DONE_OUT,
    output reg  [DW-1:0] RDATA_OUT,
    // External bus pins
    output reg  [AW-1:0] ADDR_OUT,
    output reg           ALE_OUT,
    output reg           RD_N_OUT,
    output reg           WR_N_OUT,
    output reg           CTRL_OE_OUT,
    output reg  [DW-1:0] DATA_OUT,
    output reg           DATA_OE_OUT,
    input  wire [DW-1:0] DATA_IN,
    input  wire          READY_IN,
    output reg           REFERENCE_CLOCK_OUTPUT_OUT,
    // Arbitration pins
    input  wire          HOLD_N_IN,
    output reg           RELEASE_ACKNOWLEDGE_N_OUT,
    output reg           BUS_REGAIN_REQUEST_N_OUT
);

    // ==========
    // Declarations
    reg  [`TIMING_W-1:0] timing0;         // Window 0 timing
    reg  [`TIMING_W-1:0] timing1;         // Window 1 timing
    reg  [3:0]           state;           // Sequencer state
    reg  [3:0]           next_state;      // Next state
    reg                  cur_wr;          // Request is a write
    reg                  cur_win;         // Request window
    reg                  last_win;        // Previous cycle's window
    reg                  ready_async_st;  // Extra stage for async READY
    reg                  load;            // Start a new phase
    reg  [4:0]           load_val;        // Phase length minus one
    reg                  finish_access;   // Strobe rises on this edge
    wire [`TIMING_W-1:0] tcfg;            // Current window timing
    wire                 phase_zero;      // Current phase elapsed
    wire                 ready_s;         // READY after two flops
    wire                 hold_n_s;        // Release request, synced
    wire [DW-1:0]        data_s;          // Synced read data
    wire                 ready_sample;    // Sample chosen by mode
    wire                 ready_active;    // READY at its asserted level
    wire                 take_req;        // Request accepted this cycle
    wire [1:0]           cmd_len;         // Command delay periods
    wire                 wsetup_len;      // Write setup periods
    wire [1:0]           hold_len;        // Hold phase periods
    wire [2:0]           setup_len;       // Address setup periods minus one
    wire [1:0]           ext_len;         // Setup extension periods

    // ==========
    // Pin synchronisers
    pin_sync #(.W(1), .RST(1'b0)) u_ready_sync (
        .clk_in   (CLK_SYS_IN),
        .rst_b_in (RST_B_IN),
        .ce_in    (CE_IN),
        .d_in     (READY_IN),
        .q_out    (ready_s)
    );

    // Idle value high: no release request out of reset
    pin_sync #(.W(1), .RST(1'b1)) u_hold_sync (
        .clk_in   (CLK_SYS_IN),
        .rst_b_in (RST_B_IN),
        .ce_in    (CE_IN),
        .d_in     (HOLD_N_IN),
        .q_out    (hold_n_s)
    );

    // Read data also crosses in; it must be stable two periods early
    pin_sync #(.W(DW), .RST(1'b0)) u_data_sync (
        .clk_in   (CLK_SYS_IN),
        .rst_b_in (RST_B_IN),
        .ce_in    (CE_IN),
        .d_in     (DATA_IN),
        .q_out    (data_s)
    );

    // ==========
    // Phase timer, counting CPU clock periods
    phase_timer #(.W(5)) u_timer ( // R7
        .clk_in      (CLK_SYS_IN),
        .rst_b_in    (RST_B_IN),
        .ce_in       (CE_IN),
        .load_in     (load),
        .load_val_in (load_val),
        .zero_out    (phase_zero)
    );

    // ==========
    // Timing field decode, all from the latched request's window
    assign tcfg       = cur_win ? timing1 : timing0; // R2
    assign cmd_len    = tcfg[`TF_CMD_MSB:`TF_CMD_LSB]; // R4
    assign wsetup_len = tcfg[`TF_WSETUP_BIT]; // R4
    assign hold_len   = tcfg[`TF_HOLD_MSB:`TF_HOLD_LSB]; // R6
    assign ext_len    = (cur_win != last_win) ? tcfg[`TF_EXT_MSB:`TF_EXT_LSB] : 2'h0;
    assign setup_len  = {2'h0, tcfg[`TF_SETUP_BIT]} + {1'b0, ext_len}; // R3

    // Async mode reads one stage later, costing a wait state
    assign ready_sample = tcfg[`TF_RDY_ASYNC_BIT] ? ready_async_st : ready_s; // R9 R10
    assign ready_active = (ready_sample == tcfg[`TF_RDY_POL_BIT]); // R8

    // Taken whenever none is pending, even while released
    assign take_req = REQ_IN && !BUSY_OUT;

    // ==========
    // Next-state and phase length selection
    always @* begin
        next_state    = state;
        load          = 1'b0;
        load_val      = 5'h00;
        finish_access = 1'b0;
        case (state)
            `ST_IDLE: begin
                if (!hold_n_s) begin
                    // Nothing is running, so release is safe now
                    next_state = `ST_REL_DRIVE; // R17
                end else if (BUSY_OUT) begin
                    next_state = `ST_SETUP; // R1
                    load       = 1'b1;
                    load_val   = {2'h0, setup_len}; // R3
                end
            end
            `ST_SETUP: begin
                if (phase_zero) begin
                    load = 1'b1;
                    if (cmd_len != 2'h0) begin
                        next_state = `ST_CMD;
                        load_val   = {3'h0, cmd_len - 2'h1};
                    end else if (wsetup_len) begin
                        next_state = `ST_WSETUP;
                    end else begin
                        next_state = `ST_ACCESS; // R5
                        load_val   = tcfg[`TF_ACC_MSB:`TF_ACC_LSB];
                    end
                end
            end
            `ST_CMD: begin
                if (phase_zero) begin
                    load = 1'b1;
                    if (wsetup_len) begin
                        next_state = `ST_WSETUP;
                    end else begin
                        next_state = `ST_ACCESS;
                        load_val   = tcfg[`TF_ACC_MSB:`TF_ACC_LSB];
                    end
                end
            end
            `ST_WSETUP: begin
                if (phase_zero) begin
                    next_state = `ST_ACCESS; // R5
                    load       = 1'b1;
                    load_val   = tcfg[`TF_ACC_MSB:`TF_ACC_LSB];
                end
            end
            `ST_ACCESS, `ST_WAIT_RDY: begin
                // READY is looked at only once the mandatory part is over
                if (phase_zero) begin // R13
                    if (tcfg[`TF_RDY_EN_BIT] && !ready_active) begin
                        next_state = `ST_WAIT_RDY; // R12
                    end else begin
                        finish_access = 1'b1; // R12
                        load          = 1'b1;
                        load_val      = {3'h0, hold_len - 2'h1};
                        next_state    = (hold_len != 2'h0) ? `ST_HOLDPH : `ST_IDLE; // R6
                    end
                end
            end
            `ST_HOLDPH: begin
                if (phase_zero) begin
                    next_state = `ST_IDLE;
                end
            end
            `ST_REL_DRIVE: begin
                next_state = `ST_RELEASED; // R18
            end
            `ST_RELEASED: begin
                // Only the end of the release request starts the regain
                if (hold_n_s) begin
                    next_state = `ST_REGAIN; // R19 R20
                end
            end
            `ST_REGAIN: begin
                next_state = `ST_IDLE; // R21
            end
            default: begin
                next_state = `ST_IDLE;
            end
        endcase
    end

    // ==========
    // Sequencer state, request latch and async READY stage
    always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state          <= `ST_IDLE;
            cur_wr         <= 1'b0;
            cur_win        <= 1'b0;
            last_win       <= 1'b0;
            ready_async_st <= 1'b0;
            BUSY_OUT       <= 1'b0;
            DONE_OUT       <= 1'b0;
            RDATA_OUT      <= {DW{1'b0}};
            ADDR_OUT       <= {AW{1'b0}};
            DATA_OUT       <= {DW{1'b0}};
        end else if (CE_IN) begin
            ready_async_st <= ready_s; // R10
            state          <= next_state;
            DONE_OUT       <= 1'b0;
            if (take_req) begin
                // Request parked until the bus is ours and idle
                BUSY_OUT <= 1'b1;
                cur_wr   <= REQ_WR_IN;
                cur_win  <= REQ_WIN_IN;
                ADDR_OUT <= REQ_ADDR_IN;
                DATA_OUT <= REQ_WDATA_IN;
            end
            if (state == `ST_IDLE && next_state == `ST_SETUP) begin
                last_win <= cur_win;
            end
            if (finish_access) begin
                if (!cur_wr) begin
                    RDATA_OUT <= data_s; // R16
                end
            end
            if (BUSY_OUT && next_state == `ST_IDLE && state != `ST_IDLE &&
                state != `ST_REGAIN) begin
                BUSY_OUT <= 1'b0;
                DONE_OUT <= 1'b1;
            end
        end
    end

    // ==========
    // Pin outputs, registered from the next state
    always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ALE_OUT                    <= 1'b0;
            RD_N_OUT                   <= 1'b1;
            WR_N_OUT                   <= 1'b1;
            CTRL_OE_OUT                <= 1'b1;
            DATA_OE_OUT                <= 1'b0;
            RELEASE_ACKNOWLEDGE_N_OUT  <= 1'b1;
            BUS_REGAIN_REQUEST_N_OUT   <= 1'b1;
            REFERENCE_CLOCK_OUTPUT_OUT <= 1'b0;
        end else if (CE_IN) begin
            // Reference clock at half the CPU clock rate
            REFERENCE_CLOCK_OUTPUT_OUT <= ~REFERENCE_CLOCK_OUTPUT_OUT;
            ALE_OUT  <= (next_state == `ST_SETUP); // R1
            // Strobe rises on the very edge that ends the access
            RD_N_OUT <= !(!cur_wr && (next_state == `ST_ACCESS ||
                                      next_state == `ST_WAIT_RDY)); // R16
            WR_N_OUT <= !(cur_wr && (next_state == `ST_ACCESS ||
                                     next_state == `ST_WAIT_RDY));
            DATA_OE_OUT <= cur_wr && BUSY_OUT &&
                           (next_state == `ST_WSETUP || next_state == `ST_ACCESS ||
                            next_state == `ST_WAIT_RDY || next_state == `ST_HOLDPH);
            // Controls are driven inactive in REL_DRIVE, then floated
            CTRL_OE_OUT <= (next_state != `ST_RELEASED); // R18 R21
            RELEASE_ACKNOWLEDGE_N_OUT <= (next_state != `ST_RELEASED); // R22
            // Ask for the bus back while a request waits outside
            BUS_REGAIN_REQUEST_N_OUT <= !(next_state == `ST_RELEASED &&
                                          (BUSY_OUT || take_req)); // R22
        end
    end

    // ==========
    // Register writes
    always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            timing0 <= `TIMING_RST;
            timing1 <= `TIMING_RST;
        end else if (CE_IN && REG_WR_IN) begin
            // A change mid-cycle sets phases not yet entered; READY fields apply at once
            case (REG_ADDR_IN)
                `REG_TIMING0_OFS: begin
                    timing0 <= REG_WDATA_IN[`TIMING_W-1:0]; // R2
                end
                `REG_TIMING1_OFS: begin
                    timing1 <= REG_WDATA_IN[`TIMING_W-1:0];
                end
                default: begin
                    timing0 <= timing0;
                end
            endcase
        end
    end

    // ==========
    // Register reads, data in the cycle after the strobe only
    always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            REG_RDATA_OUT <= 32'h00000000;
        end else if (CE_IN) begin
            REG_RDATA_OUT <= 32'h00000000;
            if (REG_RD_IN) begin
                case (REG_ADDR_IN)
                    `REG_TIMING0_OFS: begin
                        REG_RDATA_OUT <= {16'h0000, timing0};
                    end
                    `REG_TIMING1_OFS: begin
                        REG_RDATA_OUT <= {16'h0000, timing1};
                    end
                    `REG_STATUS_OFS: begin
                        REG_RDATA_OUT <= {24'h000000, BUS_REGAIN_REQUEST_N_OUT,
                                          RELEASE_ACKNOWLEDGE_N_OUT, BUSY_OUT,
                                          last_win, state};
                    end
                    default: begin
                        REG_RDATA_OUT <= 32'h00000000;
                    end
                endcase
            end
        end
    end

endmodule // bus_cycle_sequencer

`default_nettype wire

/* include/bus_cycle_defines.vh */
// Constants for the external bus cycle sequencer: register offsets,
// timing-register field positions, reset values and state codes.
// Assumes inclusion by bare name from design and testbench files.
`ifndef BUS_CYCLE_DEFINES_VH
`define BUS_CYCLE_DEFINES_VH

// ==========
// Register map (byte addresses, one 32-bit word each)
`define REG_TIMING0_OFS   8'h00
`define REG_TIMING1_OFS   8'h04
`define REG_STATUS_OFS    8'h10

// ==========
// Timing register fields, one register per chip-select window
`define TF_SETUP_BIT      0
`define TF_CMD_LSB        1
`define TF_CMD_MSB        2
`define TF_WSETUP_BIT     3
`define TF_ACC_LSB        4
`define TF_ACC_MSB        8
`define TF_HOLD_LSB       9
`define TF_HOLD_MSB       10
`define TF_RDY_EN_BIT     11
`define TF_RDY_ASYNC_BIT  12
`define TF_RDY_POL_BIT    13
`define TF_EXT_LSB        14
`define TF_EXT_MSB        15
`define TIMING_W          16
`define TIMING_RST        16'h00f1

// ==========
// Sequencer state codes
`define ST_IDLE           4'h0
`define ST_SETUP          4'h1
`define ST_CMD            4'h2
`define ST_WSETUP         4'h3
`define ST_ACCESS         4'h4
`define ST_WAIT_RDY       4'h5
`define ST_HOLDPH         4'h6
`define ST_REL_DRIVE      4'h7
`define ST_RELEASED       4'h8
`define ST_REGAIN         4'h9

`endif

/* rtl/pin_sync.v */
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk_in; only stage two is read.
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
    parameter W   = 1,
    parameter RST = 1'b0
) (
    input  wire         clk_in,
    input  wire         rst_b_in,
    input  wire         ce_in,
    input  wire [W-1:0] d_in,
    output reg  [W-1:0] q_out
);

    reg [W-1:0] meta;   // First stage, read by q_out only

    // ==========
    // Synchroniser flops
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta  <= {W{RST}};
            q_out <= {W{RST}};
        end else if (ce_in) begin
            meta  <= d_in;
            q_out <= meta;
        end
    end

endmodule // pin_sync

`default_nettype wire

/* rtl/phase_timer.v */
// Down counter that times one bus cycle phase in CPU clock periods.
// Assumes load is given one cycle before the phase's first period ends.
`timescale 1ns/10ps
`default_nettype none

module phase_timer #(
    parameter W = 5
) (
    input  wire         clk_in,
    input  wire         rst_b_in,
    input  wire         ce_in,
    input  wire         load_in,
    input  wire [W-1:0] load_val_in,
    output wire         zero_out
);

    reg [W-1:0] cnt;    // Periods left in the phase, minus one

    assign zero_out = (cnt == {W{1'b0}});

    // ==========
    // Load on phase entry, then count down to zero and stop
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt <= {W{1'b0}};
        end else if (ce_in) begin
            if (load_in) begin
                cnt <= load_val_in;
            end else if (!zero_out) begin
                cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // phase_timer

`default_nettype wire

/* testbench/bus_cycle_sequencer_assertions.sv */
// Pin-level checker for the bus cycle sequencer.
// Assumes a bind onto the sequencer top module.
`timescale 1ns/10ps
`default_nettype none
module bus_cycle_checker (
    input wire logic CLK_SYS_IN,
    input wire logic RST_B_IN,
    input wire logic HOLD_N_IN,
    input wire logic BUSY_OUT,
    input wire logic DONE_OUT,
    input wire logic ALE_OUT,
    input wire logic RD_N_OUT,
    input wire logic WR_N_OUT,
    input wire logic CTRL_OE_OUT,
    input wire logic DATA_OE_OUT,
    input wire logic RELEASE_ACKNOWLEDGE_N_OUT,
    input wire logic BUS_REGAIN_REQUEST_N_OUT,
    input wire logic REFERENCE_CLOCK_OUTPUT_OUT
);
    // ==========
    // Single domain, so clock and reset once
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_B_IN);
    chk_ack_floated: assert property (!RELEASE_ACKNOWLEDGE_N_OUT |-> !CTRL_OE_OUT)
        else $error("ack while driven");
    chk_float_quiet: assert property ($fell(CTRL_OE_OUT) |->
        $past(RD_N_OUT) && $past(WR_N_OUT) && !$past(ALE_OUT)) else $error("float noisy");
    chk_regain_quiet: assert property ($rose(CTRL_OE_OUT) |->
        RD_N_OUT && WR_N_OUT && !ALE_OUT ##1 RD_N_OUT && WR_N_OUT) else $error("regain noisy");
    chk_strobe_owned: assert property (!RD_N_OUT || !WR_N_OUT |->
        CTRL_OE_OUT && RELEASE_ACKNOWLEDGE_N_OUT) else $error("strobe released");
    chk_grant_bound: assert property ($fell(HOLD_N_IN) |->
        ##[2:60] !RELEASE_ACKNOWLEDGE_N_OUT) else $error("release late");
    chk_regain_bound: assert property ($rose(HOLD_N_IN) && !RELEASE_ACKNOWLEDGE_N_OUT |->
        ##[1:5] RELEASE_ACKNOWLEDGE_N_OUT) else $error("regain late");
    chk_regain_cause: assert property ($rose(RELEASE_ACKNOWLEDGE_N_OUT) |-> $past(HOLD_N_IN))
        else $error("regain uncaused");
    chk_setup_len: assert property ($rose(ALE_OUT) |-> ##[1:5] !ALE_OUT)
        else $error("setup too long");
    chk_wdata_drive: assert property (!WR_N_OUT |-> DATA_OE_OUT)
        else $error("wdata floated");
    chk_hold_len: assert property ($rose(RD_N_OUT) || $rose(WR_N_OUT) |-> ##[0:3] DONE_OUT)
        else $error("hold too long");
    chk_done_pulse: assert property (DONE_OUT |-> !BUSY_OUT ##1 !DONE_OUT)
        else $error("done not a pulse");
    chk_regain_req: assert property (!BUS_REGAIN_REQUEST_N_OUT |-> !RELEASE_ACKNOWLEDGE_N_OUT)
        else $error("regain req while owning");
    chk_ref_toggle: assert property ($past(RST_B_IN) |-> $changed(REFERENCE_CLOCK_OUTPUT_OUT))
        else $error("ref clock stuck");
    // Main scenarios reached
    cover property ($rose(CTRL_OE_OUT));
    cover property ($rose(RD_N_OUT));
    cover property ($rose(WR_N_OUT));
endmodule // bus_cycle_checker
`default_nettype wire

/* testbench/ext_bus_partner.sv */
// Far-side model: a memory that answers reads and paces READY.
// Assumes strobes and address come registered on the same clock.
`timescale 1ns/10ps
`default_nettype none
module ext_bus_partner (
    input  wire logic        clk_in,
    input  wire logic        rd_n_in,
    input  wire logic        wr_n_in,
    input  wire logic [23:0] addr_in,
    input  wire logic [3:0]  wait_in,
    input  wire logic        pol_in,
    output logic      [15:0] data_out,
    output logic             ready_out
);
    logic [15:0] last = 16'h0; // Last value driven
    logic [3:0]  cnt  = 4'h0;  // Strobe-low periods, saturating
    logic        rdy  = 1'b0;  // Ready asserted
    wire         strobe = !rd_n_in || !wr_n_in;
    // ==========
    // Released lines show the inverse, never a stale copy
    assign data_out  = !rd_n_in ? addr_in[15:0] ^ 16'h5a5a : ~last;
    assign ready_out = rdy ? pol_in : !pol_in;
    // Ready follows the clock; dropped once the strobe rises
    always @(posedge clk_in) begin
        if (!rd_n_in) begin
            last <= data_out;
        end
        cnt <= strobe ? cnt + {3'h0, cnt != 4'hf} : 4'h0;
        rdy <= strobe && cnt >= wait_in;
    end
endmodule // ext_bus_partner
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the bus cycle sequencer.
// Assumes design, header, partner and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "bus_cycle_defines.vh"
module testbench;
    logic        clk = 0, rst_b = 0, hold_n = 1, pol = 1;
    logic        req = 0, req_wr = 0, req_win = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [23:0] req_addr = 24'h0;
    logic [15:0] req_wdata = 16'h0, wd;
    logic [3:0]  wait_c = 4'h3;
    wire  [31:0] reg_rdata;
    wire  [23:0] addr;
    wire  [15:0] rdata, dout, din;
    wire         busy, done, ale, rd_n, wr_n, oe, doe, rdy, ack_n, rq_n;
    integer      n_errors = 0, n_tests = 0;
    bus_cycle_sequencer bus_cycle_sequencer_inst (
        .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .CE_IN(1'b1), .REG_ADDR_IN(reg_addr),
        .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
        .REG_RDATA_OUT(reg_rdata), .REQ_IN(req), .REQ_WR_IN(req_wr), .REQ_WIN_IN(req_win),
        .REQ_ADDR_IN(req_addr), .REQ_WDATA_IN(req_wdata), .BUSY_OUT(busy), .DONE_OUT(done),
        .RDATA_OUT(rdata), .ADDR_OUT(addr), .ALE_OUT(ale), .RD_N_OUT(rd_n), .WR_N_OUT(wr_n),
        .CTRL_OE_OUT(oe), .DATA_OUT(dout), .DATA_OE_OUT(doe), .DATA_IN(din), .READY_IN(rdy),
        .REFERENCE_CLOCK_OUTPUT_OUT(), .HOLD_N_IN(hold_n),
        .RELEASE_ACKNOWLEDGE_N_OUT(ack_n), .BUS_REGAIN_REQUEST_N_OUT(rq_n));
    ext_bus_partner ext_bus_partner_inst (.clk_in(clk), .rd_n_in(rd_n), .wr_n_in(wr_n),
        .addr_in(addr), .wait_in(wait_c), .pol_in(pol), .data_out(din), .ready_out(rdy));
    initial forever #10 clk = ~clk;
    // ==========
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic bail;
        n_errors = n_errors + 1;
        tally_and_finish();
    endtask
    task automatic reg_w(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Data stands in the cycle after the strobe
    task automatic reg_r(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(reg_rdata, exp);
    endtask
    // One bus cycle; cyc counts edges from raising req to done
    task automatic bus_op(input logic w, input logic win, input logic [23:0] a,
                          input logic [15:0] d, output integer cyc);
        @(posedge clk);
        req <= 1'b1;
        req_wr <= w;
        req_win <= win;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        for (cyc = 2; cyc < 200; cyc = cyc + 1) begin
            @(posedge clk) #1;
            if (!wr_n) wd = dout;
            if (done === 1'b1) break;
        end
        if (cyc == 200) bail();
    endtask
    task automatic wait_ack(input logic v);
        integer i;
        for (i = 0; i < 100 && ack_n !== v; i = i + 1) @(posedge clk) #1;
        if (ack_n !== v) bail();
    endtask
    // Timing word, top field first; a = access - 1
    function automatic [31:0] tf(input [1:0] x, input p, input y, input e, input [1:0] h,
                                 input [4:0] a, input w, input [1:0] c, input s);
        tf = {16'h0, x, p, y, e, h, a, w, c, s};
    endfunction
    // ==========
    // Scenarios
    task automatic t_reset;
        reg_r(`REG_TIMING0_OFS, 32'h00f1);
        reg_r(`REG_TIMING1_OFS, 32'h00f1);
        reg_w(8'h08, 32'h1234);
        reg_r(8'h08, 32'h0);
        reg_r(`REG_STATUS_OFS, 32'hc0);
    endtask
    task automatic t_phases;
        integer n;
        bus_op(1'b0, 1'b0, 24'h001234, 16'h0, n);
        check(n, 20);
        check(rdata, 16'h1234 ^ 16'h5a5a);
        reg_w(`REG_TIMING1_OFS, 32'hffff0000 | tf(2, 0, 0, 0, 3, 2, 1, 3, 0));
        reg_r(`REG_TIMING1_OFS, tf(2, 0, 0, 0, 3, 2, 1, 3, 0));
        bus_op(1'b1, 1'b1, 24'h0000a0, 16'hbeef, n);
        check(n, 15);
        check(wd, 16'hbeef);
        bus_op(1'b1, 1'b1, 24'h0000a2, 16'h0f0f, n);
        check(n, 13);
        check(wd, 16'h0f0f);
        bus_op(1'b0, 1'b0, 24'h00beef, 16'h0, n);
        check(n, 20);
    endtask
    // Ready waits add cycles; async one more
    task automatic t_ready;
        integer p, y, n3, n5;
        integer base[2];
        for (p = 0; p < 2; p = p + 1) begin
            for (y = 0; y < 2; y = y + 1) begin
                reg_w(`REG_TIMING0_OFS, tf(0, p[0], y[0], 1, 0, 1, 0, 0, 0));
                pol <= p[0];
                wait_c <= 4'h3;
                bus_op(1'b0, 1'b0, 24'h000321, 16'h0, n3);
                check(rdata, 16'h0321 ^ 16'h5a5a);
                wait_c <= 4'h5;
                bus_op(1'b0, 1'b0, 24'h000322, 16'h0, n5);
                check(n5 - n3, 2);
                if (p == 0) base[y] = n3;
                else check(n3, base[y]);
                if (y == 1) check(base[1], base[0] + 1);
            end
        end
        reg_w(`REG_TIMING0_OFS, 32'h00f1);
    endtask
    task automatic t_release;
        integer n;
        hold_n <= 1'b0;
        wait_ack(1'b0);
        check(oe, 1'b0);
        reg_r(`REG_STATUS_OFS, 32'h80 | `ST_RELEASED);
        fork
            bus_op(1'b0, 1'b0, 24'h000042, 16'h0, n);
            begin
                repeat (8) @(posedge clk);
                check(rq_n, 1'b0);
                hold_n <= 1'b1;
            end
        join
        check(rdata, 16'h0042 ^ 16'h5a5a);
        check(rq_n, 1'b1);
        hold_n <= 1'b0;
        wait_ack(1'b0);
        hold_n <= 1'b1;
        wait_ack(1'b1);
        check(rq_n, 1'b1);
        fork
            bus_op(1'b0, 1'b0, 24'h000777, 16'h0, n);
            begin
                repeat (5) @(posedge clk);
                hold_n <= 1'b0;
            end
        join
        check(ack_n, 1'b1);
        check(rdata, 16'h0777 ^ 16'h5a5a);
        wait_ack(1'b0);
        hold_n <= 1'b1;
        wait_ack(1'b1);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_phases();
        t_ready();
        t_release();
        tally_and_finish();
    end
endmodule // testbench
bind bus_cycle_sequencer bus_cycle_checker bus_cycle_checker_inst (.*);
`default_nettype wire
